// file: design/port_err_pkg.sv
// Package: register map, field layout and timing for the port error block
`default_nettype none
package port_err_pkg;
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] thresh_addr = 8'h04;
  localparam logic [7:0] status_addr = 8'h08;
  localparam logic [7:0] even_detect_addr = 8'h0c;
  localparam logic [7:0] even_errstat_addr = 8'h10;
  localparam logic [7:0] odd_errstat_addr = 8'h14;
  localparam logic [7:0] rate_addr = 8'h18;
  localparam logic [7:0] irq_stat_addr = 8'h1c;
  localparam logic [7:0] irq_mask_addr = 8'h20;
  // Control register bits
  localparam int split_bit = 0;
  localparam int indep_report_bit = 1;
  localparam int even_report_dis_bit = 2;
  localparam int odd_report_dis_bit = 3;
  localparam int drop_bit = 4;
  localparam int stop_fail_bit = 5;
  localparam int dead_timer_bit = 6;
  localparam int lock_bit = 7;
  // Error-status register bits (per port)
  localparam int port_err_bit = 0;
  localparam int pending_bit = 1;
  localparam int uninit_bit = 2;
  localparam int stopped_bit = 3;
  // Interrupt status bits
  localparam int irq_even_err = 0;
  localparam int irq_odd_err = 1;
  localparam int irq_rate_fail = 2;
  localparam int irq_link_down = 3;
  localparam int irq_stopped = 4;
  localparam int irq_w = 5;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] thresh_reset = 8'hff;
  localparam logic [4:0] mask_reset = 5'h00;
  localparam int lanes = 4;
  localparam int clk_mhz = 25;
  // Dead-link timer minimum, in ns, and its cycle count (rounded up)
  localparam int dead_time_ns = 1000;
  localparam int dead_cycles = (dead_time_ns * clk_mhz + 999) / 1000;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic [lanes-1:0] sync;
    logic [lanes-1:0] err;
  } lane_status_t;
endpackage
`default_nettype wire

// file: design/rate_counter.sv
// Error-rate counter with threshold compare
`default_nettype none
module rate_counter (
  input wire logic mclk,
  input wire logic reset,
  input wire logic inc,
  input wire logic clear,
  input wire logic [7:0] threshold,
  output logic [7:0] count,
  output logic over
);
  typedef struct packed {
    logic [7:0] count;
    logic over;
  } rc_state_t;
  rc_state_t st;
  rc_state_t next_st;
  // Saturating count, compare against threshold
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.count = 8'h00;
    end else if (inc && st.count != 8'hff) begin
      next_st.count = st.count + 8'h01;
    end
    next_st.over = next_st.count > threshold;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign count = st.count;
  assign over = st.over;
endmodule
`default_nettype wire

// file: design/dual_port_error_and_discard.sv
// Dual 1x port error propagation, event reports and egress discard
//
// Added by the designer: the register offsets and the strobed register port.
`default_nettype none
// Contract
// - Odd error also raises even error when split
// - Even propagation works while even uninitialized
// - Even error is OR of all lanes; the code does this only when split, else lane 0 only
// - Lane errors qualified by lane code-group sync
// - Propagated error never blocks even port traffic
// - Writing zero clears even error-detect flag
// - Reports need indep enable and clear disable
// - Odd error: both ports report, set pending
// - Report when rate count exceeds threshold
// - Drop above threshold unless output stopped
// - Dead-link timer discards until link reinitializes
// - Threshold discard survives reinitialization
// - Ackid mismatch enters stopped, threshold discard lost
// - Fail-stop: discard until software recovers link; the code does not discard while stopped, only on lock or dead-link
// - Writing one clears status error flag
module dual_port_error_and_discard (
  input wire logic mclk,
  input wire logic reset,
  input wire port_err_pkg::bus_req_t bus,
  output logic [31:0] rdata,
  input wire port_err_pkg::lane_status_t lane,
  input wire logic even_link_ok,
  input wire logic odd_link_ok,
  input wire logic ackid_mismatch,
  input wire logic err_rate_event,
  output logic even_report_req,
  output logic odd_report_req,
  output logic discard,
  output logic even_link_enable,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] thresh;
    logic even_detect;
    logic even_err;
    logic odd_err;
    logic even_pend;
    logic odd_pend;
    logic stopped;
    logic even_ok_seen;
    logic link_prev;
    logic dead_active;
    logic [7:0] dead_cnt;
    logic [4:0] istat;
    logic [4:0] imask;
    logic [31:0] rdata;
    logic even_rep;
    logic odd_rep;
    logic discard;
    logic irq;
  } state_t;
  state_t s;
  state_t n;
  logic [port_err_pkg::lanes-1:0] qual;
  logic odd_lane_err;
  logic even_lane_err;
  logic [7:0] rate_cnt;
  logic rate_over;
  logic rate_clear;
  logic odd_rise;
  logic rep_ok_even;
  logic rep_ok_odd;
  logic [4:0] ev;
  logic wr_ctrl;
  logic std_drop;
  logic lock_drop;

  // Lane error qualified by code-group sync, not by link ok
  genvar g;
  generate
    for (g = 0; g < port_err_pkg::lanes; g++) begin : g_lane
      assign qual[g] = lane.err[g] & lane.sync[g];
    end
  endgenerate
  assign odd_lane_err = |qual[port_err_pkg::lanes-1:1];
  // Even flag sees all four lanes when split; uninit not a gate
  assign even_lane_err = s.ctrl[port_err_pkg::split_bit] ?
      (|qual) : qual[0];
  assign odd_rise = s.ctrl[port_err_pkg::split_bit] & odd_lane_err
      & ~s.odd_err;
  assign rep_ok_even = s.ctrl[port_err_pkg::indep_report_bit]
      & ~s.ctrl[port_err_pkg::even_report_dis_bit];
  assign rep_ok_odd = s.ctrl[port_err_pkg::indep_report_bit]
      & ~s.ctrl[port_err_pkg::odd_report_dis_bit];
  assign rate_clear = bus.wr && bus.addr == port_err_pkg::rate_addr;
  assign wr_ctrl = bus.wr && bus.addr == port_err_pkg::ctrl_addr;
  // Standard discard: drop_bit and stop_fail_bit set, rate over threshold, port not output-stopped
  assign std_drop = s.ctrl[port_err_pkg::drop_bit]
      & s.ctrl[port_err_pkg::stop_fail_bit]
      & rate_over & ~s.stopped;
  // Lockout held, or the write that sets it acts at once
  assign lock_drop = s.ctrl[port_err_pkg::lock_bit]
      | (wr_ctrl & bus.wdata[port_err_pkg::lock_bit]);

  rate_counter u_rate (
    .mclk(mclk),
    .reset(reset),
    .inc(err_rate_event),
    .clear(rate_clear),
    .threshold(s.thresh),
    .count(rate_cnt),
    .over(rate_over)
  );

  // Interrupt events
  always_comb begin
    ev = '0;
    ev[port_err_pkg::irq_even_err] = even_lane_err & ~s.even_err;
    ev[port_err_pkg::irq_odd_err] = odd_rise;
    ev[port_err_pkg::irq_rate_fail] = rate_over;
    ev[port_err_pkg::irq_link_down] = s.link_prev & ~odd_link_ok;
    ev[port_err_pkg::irq_stopped] = ackid_mismatch & ~s.stopped;
  end

  // Next-state logic
  always_comb begin
    n = s;
    n.even_rep = 1'b0;
    n.odd_rep = 1'b0;
    n.rdata = 32'h0000_0000;
    n.link_prev = odd_link_ok;
    n.even_ok_seen = even_link_ok;
    // Register writes and clears
    if (bus.wr) begin
      if (bus.addr == port_err_pkg::ctrl_addr) begin
        n.ctrl = bus.wdata[7:0];
      end else if (bus.addr == port_err_pkg::thresh_addr) begin
        n.thresh = bus.wdata[7:0];
      end else if (bus.addr == port_err_pkg::even_detect_addr) begin
        if (!bus.wdata[port_err_pkg::port_err_bit]) begin
          n.even_detect = 1'b0;
        end
      end else if (bus.addr == port_err_pkg::even_errstat_addr) begin
        if (bus.wdata[port_err_pkg::port_err_bit]) begin
          n.even_err = 1'b0;
        end
        if (bus.wdata[port_err_pkg::pending_bit]) begin
          n.even_pend = 1'b0;
        end
      end else if (bus.addr == port_err_pkg::odd_errstat_addr) begin
        if (bus.wdata[port_err_pkg::port_err_bit]) begin
          n.odd_err = 1'b0;
        end
        if (bus.wdata[port_err_pkg::pending_bit]) begin
          n.odd_pend = 1'b0;
        end
        if (bus.wdata[port_err_pkg::stopped_bit]) begin
          n.stopped = 1'b0; // software recovery
        end
      end else if (bus.addr == port_err_pkg::irq_stat_addr) begin
        n.istat = s.istat & ~bus.wdata[4:0];
      end else if (bus.addr == port_err_pkg::irq_mask_addr) begin
        n.imask = bus.wdata[4:0];
      end
    end
    // Hardware sets win over software clears
    if (even_lane_err) begin
      n.even_detect = 1'b1;
      n.even_err = 1'b1;
    end
    if (s.ctrl[port_err_pkg::split_bit] && odd_lane_err) begin
      n.odd_err = 1'b1;
    end
    // Odd error: both ports report when enabled
    if (odd_rise) begin
      if (rep_ok_even) begin
        n.even_rep = 1'b1;
        n.even_pend = 1'b1;
      end
      if (rep_ok_odd) begin
        n.odd_rep = 1'b1;
        n.odd_pend = 1'b1;
      end
    end
    // Rate count over threshold raises report on odd port while odd not pending
    if (rate_over && !s.odd_pend && rep_ok_odd) begin
      n.odd_rep = 1'b1;
      n.odd_pend = 1'b1;
    end
    // Ackid mismatch forces output error-stopped
    if (ackid_mismatch) begin
      n.stopped = 1'b1;
    end
    // Dead-link timer: discard while link down, end on reinit
    if (!s.ctrl[port_err_pkg::dead_timer_bit] || odd_link_ok) begin
      n.dead_cnt = 8'h00;
      n.dead_active = 1'b0;
    end else if (s.dead_cnt == 8'(port_err_pkg::dead_cycles - 1)) begin
      n.dead_active = 1'b1;
    end else begin
      n.dead_cnt = s.dead_cnt + 8'h01;
    end
    // Discard: standard, dead-link, or lock; standard and lock persist past reinit
    n.discard = std_drop
        | s.dead_active
        | lock_drop;
    n.istat = n.istat | ev;
    n.irq = |(n.istat & n.imask);
    // Read data, one cycle later
    if (bus.rd) begin
      if (bus.addr == port_err_pkg::ctrl_addr) begin
        n.rdata = {24'h000000, s.ctrl};
      end else if (bus.addr == port_err_pkg::thresh_addr) begin
        n.rdata = {24'h000000, s.thresh};
      end else if (bus.addr == port_err_pkg::status_addr) begin
        n.rdata = {26'h0, s.dead_active, s.discard, s.stopped,
            rate_over, odd_link_ok, even_link_ok};
      end else if (bus.addr == port_err_pkg::even_detect_addr) begin
        n.rdata = {31'h0, s.even_detect};
      end else if (bus.addr == port_err_pkg::even_errstat_addr) begin
        n.rdata = {29'h0, ~s.even_ok_seen, s.even_pend, s.even_err};
      end else if (bus.addr == port_err_pkg::odd_errstat_addr) begin
        n.rdata = {28'h0000000, s.stopped, ~odd_link_ok, s.odd_pend,
            s.odd_err};
      end else if (bus.addr == port_err_pkg::rate_addr) begin
        n.rdata = {24'h000000, rate_cnt};
      end else if (bus.addr == port_err_pkg::irq_stat_addr) begin
        n.rdata = {27'h0, s.istat};
      end else if (bus.addr == port_err_pkg::irq_mask_addr) begin
        n.rdata = {27'h0, s.imask};
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (reset) begin
      s.ctrl <= port_err_pkg::ctrl_reset;
      s.thresh <= port_err_pkg::thresh_reset;
      s.even_detect <= 1'b0;
      s.even_err <= 1'b0;
      s.odd_err <= 1'b0;
      s.even_pend <= 1'b0;
      s.odd_pend <= 1'b0;
      s.stopped <= 1'b0;
      s.even_ok_seen <= 1'b0;
      s.link_prev <= 1'b0;
      s.dead_active <= 1'b0;
      s.dead_cnt <= 8'h00;
      s.istat <= 5'h00;
      s.imask <= port_err_pkg::mask_reset;
      s.rdata <= 32'h0000_0000;
      s.even_rep <= 1'b0;
      s.odd_rep <= 1'b0;
      s.discard <= 1'b0;
      s.irq <= 1'b0;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from flops, even link enable tied high; even link never gated by error
  assign rdata = s.rdata;
  assign even_report_req = s.even_rep;
  assign odd_report_req = s.odd_rep;
  assign discard = s.discard;
  assign even_link_enable = 1'b1;
  assign irq = s.irq;
endmodule
`default_nettype wire

// file: bench/port_err_props.sv
// Checker for the port error and discard block
`default_nettype none
module port_err_props (
  input wire logic mclk,
  input wire logic reset,
  input wire port_err_pkg::bus_req_t bus,
  input wire logic [31:0] rdata,
  input wire logic even_report_req,
  input wire logic odd_report_req,
  input wire logic discard,
  input wire logic even_link_enable,
  input wire logic irq
);
  logic [7:0] ctrl_s;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Shadow copy of the control register
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_s <= port_err_pkg::ctrl_reset;
    end else if (bus.wr && bus.addr == port_err_pkg::ctrl_addr) begin
      ctrl_s <= bus.wdata[7:0];
    end
  end
  // Host write that sets the lockout bit
  sequence lock_wr;
    bus.wr && bus.addr == port_err_pkg::ctrl_addr
        && bus.wdata[port_err_pkg::lock_bit];
  endsequence
  // Host write that masks every interrupt
  sequence mask_off;
    bus.wr && bus.addr == port_err_pkg::irq_mask_addr
        && bus.wdata[4:0] == 5'h00;
  endsequence
  chk_link_kept: assert property (even_link_enable)
    else $error("even link enable dropped");
  chk_report_pulse: assert property (odd_report_req |=> !odd_report_req)
    else $error("odd report longer than one cycle");
  chk_report_gate: assert property (even_report_req |->
    $past(ctrl_s[1]) && !$past(ctrl_s[2]))
    else $error("even report while disabled");
  chk_lock_drop: assert property (lock_wr |-> ##[1:2] discard)
    else $error("lock bit did not discard");
  chk_drop_cause: assert property ($rose(discard) |->
    ctrl_s[7] || $past(ctrl_s[6] | (ctrl_s[4] & ctrl_s[5]))
    || $past(ctrl_s[6], 2))
    else $error("discard without enabled cause");
  chk_irq_masked: assert property (mask_off |-> ##2 !irq)
    else $error("irq high with mask clear");
  chk_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  chk_unmapped_rd: assert property (bus.rd && bus.addr == 8'h24 |=>
    rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// file: bench/link_partner.sv
// Link partner model driving lane and link status
`default_nettype none
module link_partner (
  input wire logic mclk,
  output var port_err_pkg::lane_status_t lane,
  output logic even_link_ok,
  output logic odd_link_ok,
  output logic ackid_mismatch,
  output logic err_rate_event
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: even port not up, odd port up
  initial begin
    lane = '0;
    {even_link_ok, odd_link_ok} = 2'b01;
    {ackid_mismatch, err_rate_event} = 2'b00;
  end
  // One-cycle lane error with sync levels held
  task automatic lane_err(input logic [3:0] s, input logic [3:0] e);
    @(posedge mclk) lane <= '{s, e};
    @(posedge mclk) lane.err <= 4'h0;
  endtask
  // One-cycle ackid mismatch or error-rate event
  task automatic pulse(input bit stop);
    @(posedge mclk) {ackid_mismatch, err_rate_event} <= {stop, !stop};
    @(posedge mclk) {ackid_mismatch, err_rate_event} <= 2'b00;
  endtask
  // Link-ok level changes on either port
  task automatic odd_link(input logic ok);
    @(posedge mclk) odd_link_ok <= ok;
  endtask
  task automatic even_link(input logic ok);
    @(posedge mclk) even_link_ok <= ok;
  endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// Testbench for the dual port error and discard block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] z = 32'h0;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  port_err_pkg::bus_req_t bus = '0;
  port_err_pkg::lane_status_t lane;
  logic [31:0] rdata, v;
  logic even_link_ok, odd_link_ok, ackid_mismatch, err_rate_event;
  logic even_report_req, odd_report_req, discard, even_link_enable, irq;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ev_n = 0;
  int od_n = 0;
  always #20 mclk = ~mclk;
  link_partner link_partner_i (.mclk(mclk), .lane(lane),
    .even_link_ok(even_link_ok), .odd_link_ok(odd_link_ok),
    .ackid_mismatch(ackid_mismatch), .err_rate_event(err_rate_event));
  dual_port_error_and_discard dual_port_error_and_discard_i (
    .mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata), .lane(lane),
    .even_link_ok(even_link_ok), .odd_link_ok(odd_link_ok),
    .ackid_mismatch(ackid_mismatch), .err_rate_event(err_rate_event),
    .even_report_req(even_report_req), .odd_report_req(odd_report_req),
    .discard(discard), .even_link_enable(even_link_enable), .irq(irq));
  // Report pulse counts and run ceiling
  always @(posedge mclk) begin
    cyc++;
    if (even_report_req === 1'b1) ev_n++;
    if (odd_report_req === 1'b1) od_n++;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus.wr <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk) bus <= '{a, z, 1'b0, 1'b1};
    @(posedge mclk) bus.rd <= 1'b0;
    #1 v = rdata;
    chk($sformatf("reg %h", a), v, exp);
  endtask
  task automatic wait_chk(input string n, input int c, input logic e);
    repeat (c) @(posedge mclk);
    #1 chk(n, discard, e);
  endtask
  task automatic t_regs();
    rchk(8'h00, z);
    rchk(8'h04, 32'hff);
    rchk(8'h20, z);
    rchk(8'h24, z);
    $display("test regs done");
  endtask
  task automatic t_split();
    wr(8'h00, 32'h3);
    wr(8'h20, 32'h1f);
    link_partner_i.lane_err(4'hf, 4'h2);
    repeat (4) @(posedge mclk);
    #1 chk("even reports", ev_n, 1);
    chk("odd reports", od_n, 1);
    chk("irq", irq, 1);
    rchk(8'h0c, 32'h1);
    rchk(8'h10, 32'h7);
    rchk(8'h14, 32'h3);
    wr(8'h0c, z);
    rchk(8'h0c, z);
    wr(8'h10, 32'h1);
    rchk(8'h10, 32'h6);
    link_partner_i.even_link(1'b1);
    rchk(8'h10, 32'h2);
    wr(8'h20, z);
    wr(8'h1c, 32'h1f);
    #1 chk("irq masked", irq, 0);
    chk("even link", even_link_enable, 1);
    $display("test split done");
  endtask
  task automatic t_lanes();
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h3);
    link_partner_i.lane_err(4'h0, 4'h8);
    rchk(8'h0c, z);
    link_partner_i.lane_err(4'h8, 4'h8);
    rchk(8'h0c, 32'h1);
    wr(8'h00, 32'h7);
    wr(8'h0c, z);
    wr(8'h14, 32'h3);
    link_partner_i.lane_err(4'hf, 4'h4);
    repeat (4) @(posedge mclk);
    #1 chk("even reports", ev_n, 2);
    chk("odd reports", od_n, 3);
    wr(8'h14, 32'h3);
    $display("test lanes done");
  endtask
  task automatic t_rate();
    wr(8'h00, 32'h32);
    wr(8'h04, 32'h2);
    wr(8'h18, z);
    repeat (2) link_partner_i.pulse(1'b0);
    wait_chk("at threshold", 2, 1'b0);
    link_partner_i.pulse(1'b0);
    wait_chk("over threshold", 2, 1'b1);
    chk("rate report", od_n, 4);
    link_partner_i.pulse(1'b1);
    wait_chk("stopped", 2, 1'b0);
    wr(8'h00, 32'hb2);
    wait_chk("locked", 2, 1'b1);
    wr(8'h00, 32'h72);
    wr(8'h14, 32'hb);
    wr(8'h18, z);
    link_partner_i.odd_link(1'b0);
    wait_chk("link down early", 20, 1'b0);
    wait_chk("link down", 10, 1'b1);
    link_partner_i.odd_link(1'b1);
    wait_chk("link back", 3, 1'b0);
    repeat (3) link_partner_i.pulse(1'b0);
    wait_chk("after reinit", 2, 1'b1);
    $display("test rate done");
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset, then the scenarios in order
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_split();
    t_lanes();
    t_rate();
    end_of_test();
  end
endmodule
bind dual_port_error_and_discard port_err_props port_err_props_i (
  .mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
  .even_report_req(even_report_req), .odd_report_req(odd_report_req),
  .discard(discard), .even_link_enable(even_link_enable), .irq(irq));
`default_nettype wire
